// [rtl/pbc_defines.svh]
// constants of the phy basic control register block
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH
`define PBC_REG_CTRL 5'h00
`define PBC_PHY_ADDR 5'h01
`define PBC_OP_READ 2'h2
`define PBC_OP_WRITE 2'h1
`define PBC_CTRL_RST 16'h3080
`define PBC_BIT_RESET 15
`define PBC_BIT_LOOP 14
`define PBC_BIT_SPEED 13
`define PBC_BIT_AN_EN 12
`define PBC_BIT_PDOWN 11
`define PBC_BIT_ISOLATE 10
`define PBC_BIT_RESTART 9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COLL 7
`define PBC_RSVD_HI 6
`define PBC_HDR_LAST 4'hB
`define PBC_DATA_LAST 4'hF
`define PBC_CLK_MHZ 20
`define PBC_SWRST_NS 1000
`define PBC_SWRST_CYC ((`PBC_SWRST_NS * `PBC_CLK_MHZ + 999) / 1000)
`endif

// [rtl/pbc_pkg.sv]
// types of the phy basic control register block
package pbc_pkg;
  typedef enum logic [2:0] {
    PBC_IDLE, PBC_START, PBC_HDR, PBC_TA1, PBC_TA2, PBC_DATA
  } pbc_mgmt_state_type;

  typedef struct packed {
    logic reset;
    logic loopback;
    logic speed_100;
    logic an_enable;
    logic power_down;
    logic isolate;
    logic restart_an;
    logic duplex;
    logic coll_test;
    logic [6:0] rsvd;
  } pbc_ctrl_type;

  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic full_duplex;
    logic an_enable;
    logic an_restart;
    logic power_down;
    logic isolate;
    logic soft_reset;
  } pbc_mode_type;

  typedef struct packed {
    logic [7:0] cnt;
    logic busy;
    logic done;
  } pbc_tmr_state_type;

  typedef struct packed {
    logic mdc_m, mdc_s, mdc_p;
    logic mdio_m, mdio_s;
    logic lbe_m, lbe_s, lbv_m, lbv_s, pdn_m, pdn_s;
    pbc_mgmt_state_type fsm;
    logic [3:0] cnt;
    logic [11:0] hdr;
    logic [15:0] shift;
    logic is_read;
    logic hit;
    logic mdio_out;
    logic mdio_oe_n;
    logic rst_start;
    pbc_ctrl_type ctrl;
    pbc_mode_type mode;
  } pbc_state_type;
endpackage : pbc_pkg

// [rtl/pbc_rst_timer.sv]
// timer that stretches the software reset to its full length
`include "pbc_defines.svh"
module pbc_rst_timer import pbc_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // control
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  localparam logic [7:0] CYC = 8'(`PBC_SWRST_CYC);
  pbc_tmr_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start_i) begin
      s_d.busy = 1'b1;
      s_d.cnt = CYC;
    end else if (s_q.busy) begin
      s_d.cnt = s_q.cnt - 8'h01;
      if (s_q.cnt == 8'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o = s_q.busy;
  assign done_o = s_q.done;
endmodule : pbc_rst_timer

// [rtl/pbc_ctrl_reg.sv]
// basic control register served over the management frame interface
`include "pbc_defines.svh"
module pbc_ctrl_reg import pbc_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // management pins, data pin split in three
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n_o,
  // hardware configuration and link power request
  input wire logic cfg_loop_override_i,
  input wire logic cfg_loop_value_i,
  input wire logic link_power_down_i,
  // auto-negotiation results
  input wire logic an_speed_100_i,
  input wire logic an_full_duplex_i,
  // mode to the rest of the device
  output pbc_mode_type mode_o
);
  pbc_state_type s_q, s_d;
  logic rst_busy;
  logic rst_done;
  logic rise;
  logic [15:0] wdata;

  function automatic logic [15:0] pbc_read_view(input pbc_ctrl_type c);
    logic [15:0] v;
    v = c;
    if (c.an_enable) begin
      v[`PBC_BIT_DUPLEX] = 1'b1;
    end
    return v;
  endfunction : pbc_read_view

  pbc_rst_timer pbc_rst_timer_inst (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .start_i(s_q.rst_start),
    .busy_o(rst_busy),
    .done_o(rst_done)
  );

  assign rise = s_q.mdc_s & ~s_q.mdc_p;
  assign wdata = {s_q.shift[14:0], s_q.mdio_s};

  always_comb begin
    s_d = s_q;
    s_d.rst_start = 1'b0;
    // pin synchronisers
    s_d.mdc_m = mdc_i;
    s_d.mdc_s = s_q.mdc_m;
    s_d.mdc_p = s_q.mdc_s;
    s_d.mdio_m = mdio_i;
    s_d.mdio_s = s_q.mdio_m;
    s_d.lbe_m = cfg_loop_override_i;
    s_d.lbe_s = s_q.lbe_m;
    s_d.lbv_m = cfg_loop_value_i;
    s_d.lbv_s = s_q.lbv_m;
    s_d.pdn_m = link_power_down_i;
    s_d.pdn_s = s_q.pdn_m;
    // self-clearing bits
    s_d.ctrl.restart_an = 1'b0;
    if (s_q.ctrl.reset && rst_done) begin
      s_d.ctrl.reset = 1'b0;
    end
    if (rise) begin
      case (s_q.fsm)
        PBC_IDLE: begin
          // preamble ones are skipped; a zero is the start bit
          if (!s_q.mdio_s) begin
            s_d.fsm = PBC_START;
          end
        end
        PBC_START: begin
          s_d.fsm = s_q.mdio_s ? PBC_HDR : PBC_IDLE;
          s_d.cnt = 4'h0;
        end
        PBC_HDR: begin
          s_d.hdr = {s_q.hdr[10:0], s_q.mdio_s};
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == `PBC_HDR_LAST) begin
            s_d.fsm = PBC_TA1;
          end
        end
        PBC_TA1: begin
          s_d.is_read = s_q.hdr[11:10] == `PBC_OP_READ;
          s_d.hit = s_q.hdr[9:5] == `PBC_PHY_ADDR &&
                    s_q.hdr[4:0] == `PBC_REG_CTRL;
          if (s_q.hdr[11:10] != `PBC_OP_READ &&
              s_q.hdr[11:10] != `PBC_OP_WRITE) begin
            s_d.fsm = PBC_IDLE;
          end else begin
            s_d.fsm = PBC_TA2;
          end
          if (s_d.is_read && s_d.hit) begin
            s_d.mdio_oe_n = 1'b0;
            s_d.mdio_out = 1'b0;
          end
        end
        PBC_TA2: begin
          s_d.fsm = PBC_DATA;
          s_d.cnt = 4'h0;
          if (s_q.is_read) begin
            s_d.shift = pbc_read_view(s_q.ctrl);
            s_d.mdio_out = s_d.shift[15];
            s_d.shift = {s_d.shift[14:0], 1'b0};
          end
        end
        PBC_DATA: begin
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.is_read) begin
            s_d.mdio_out = s_q.shift[15];
            s_d.shift = {s_q.shift[14:0], 1'b0};
          end else begin
            s_d.shift = wdata;
          end
          if (s_q.cnt == `PBC_DATA_LAST) begin
            s_d.fsm = PBC_IDLE;
            s_d.mdio_oe_n = 1'b1;
            s_d.mdio_out = 1'b0;
            // a write during reset is dropped to keep defaults intact
            if (!s_q.is_read && s_q.hit && !s_q.ctrl.reset) begin
              if (wdata[`PBC_BIT_RESET]) begin
                s_d.ctrl = `PBC_CTRL_RST;
                s_d.ctrl.reset = 1'b1;
                s_d.rst_start = 1'b1;
              end else begin
                s_d.ctrl.reset = 1'b0;
                s_d.ctrl.loopback = wdata[`PBC_BIT_LOOP];
                s_d.ctrl.speed_100 = wdata[`PBC_BIT_SPEED];
                s_d.ctrl.an_enable = wdata[`PBC_BIT_AN_EN];
                s_d.ctrl.power_down = wdata[`PBC_BIT_PDOWN];
                s_d.ctrl.isolate = wdata[`PBC_BIT_ISOLATE];
                s_d.ctrl.restart_an = wdata[`PBC_BIT_RESTART];
                if (!wdata[`PBC_BIT_AN_EN]) begin
                  s_d.ctrl.duplex = wdata[`PBC_BIT_DUPLEX];
                end
                s_d.ctrl.coll_test = wdata[`PBC_BIT_COLL];
                s_d.ctrl.rsvd = wdata[`PBC_RSVD_HI:0];
              end
            end
          end
        end
        default: begin
          s_d.fsm = PBC_IDLE;
        end
      endcase
    end
    // mode drawn from the next register value so it follows writes at once
    s_d.mode.loopback = s_q.lbe_s ? s_q.lbv_s : s_d.ctrl.loopback;
    s_d.mode.an_enable = s_d.ctrl.an_enable;
    s_d.mode.speed_100 = s_d.ctrl.an_enable ? an_speed_100_i :
                         s_d.ctrl.speed_100;
    s_d.mode.full_duplex = s_d.mode.loopback ? 1'b1 :
                           s_d.ctrl.an_enable ? an_full_duplex_i :
                           s_d.ctrl.duplex;
    s_d.mode.an_restart = s_d.ctrl.restart_an;
    s_d.mode.power_down = s_d.ctrl.power_down | s_q.pdn_s;
    s_d.mode.isolate = s_d.ctrl.isolate;
    s_d.mode.soft_reset = s_d.ctrl.reset;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.fsm <= PBC_IDLE;
      s_q.mdio_oe_n <= 1'b1;
      s_q.ctrl <= `PBC_CTRL_RST;
      s_q.mode.an_enable <= 1'b1;
      s_q.mode.speed_100 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign mdio_o = s_q.mdio_out;
  assign mdio_oe_n_o = s_q.mdio_oe_n;
  assign mode_o = s_q.mode;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence reset_entry_s;
    $rose(s_q.ctrl.reset);
  endsequence
  sequence reset_exit_s;
    rst_busy ##[1:40] !s_q.ctrl.reset;
  endsequence

  reset_defaults_a: assert property (
    reset_entry_s |-> s_q.ctrl[14:0] == 15'(`PBC_CTRL_RST) && !rst_busy
  ) else $error("reset did not restore defaults");
  reset_length_a: assert property (
    reset_entry_s |-> ##1 reset_exit_s
  ) else $error("reset bit did not clear in time");
  // the first data bit on the pin is bit 15 of the read view
  reset_reads_one_a: assert property (
    rise && s_q.fsm == PBC_TA2 && s_q.is_read && s_q.ctrl.reset
    |=> s_q.mdio_out
  ) else $error("reset bit not read as one");
  loop_select_a: assert property (
    ##1 s_q.mode.loopback == ($past(s_q.lbe_s) ? $past(s_q.lbv_s) :
                              s_q.ctrl.loopback)
  ) else $error("loopback selection wrong");
  speed_select_a: assert property (
    !s_q.ctrl.an_enable |-> s_q.mode.speed_100 == s_q.ctrl.speed_100
  ) else $error("forced speed not applied");
  power_or_a: assert property (
    ##1 s_q.mode.power_down == (s_q.ctrl.power_down | $past(s_q.pdn_s))
  ) else $error("power down request lost");
  isolate_follow_a: assert property (
    s_q.mode.isolate == s_q.ctrl.isolate
  ) else $error("isolate not applied");
  restart_pulse_a: assert property (
    s_q.mode.an_restart |=> !s_q.mode.an_restart && !s_q.ctrl.restart_an
  ) else $error("restart did not self clear");
  // bit 8 leaves the pin on the seventh data rise of a read
  duplex_ro_a: assert property (
    rise && s_q.fsm == PBC_DATA && s_q.is_read && s_q.cnt == 4'h6 &&
    s_q.ctrl.an_enable |=> s_q.mdio_out
  ) else $error("duplex not read as one");
  loop_duplex_a: assert property (
    s_q.mode.loopback |-> s_q.mode.full_duplex
  ) else $error("duplex bit affects loopback");
  read_turn_a: assert property (
    $fell(s_q.mdio_oe_n) |-> !s_q.mdio_out ##1 !s_q.mdio_oe_n
  ) else $error("turnaround zero not driven");
endmodule : pbc_ctrl_reg

// [testbench/pbc_mac_model.sv]
// management frame master standing in for the controller
`include "pbc_defines.svh"
module pbc_mac_model (
  // clock
  input wire logic clk_i,
  // management pins
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_en_o = 1'b0;
  end
  // mdc period of 10 mclk; data moves while mdc is low, sampled at the rise
  task automatic bit_slot(input logic b, input logic drv, output logic s);
    @(posedge clk_i);
    mdc_o <= 1'b0;
    mdio_o <= b;
    mdio_en_o <= drv;
    repeat (5) @(posedge clk_i);
    s = mdio_i;
    mdc_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : bit_slot
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    logic wr;
    hdr = {2'b01, op, phy, rg};
    wr = (op == `PBC_OP_WRITE);
    for (int i = 0; i < 32; i++) bit_slot(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_slot(hdr[i], 1'b1, s);
    // on a read the turnaround and data are left to the device
    bit_slot(1'b1, wr, s);
    bit_slot(1'b0, wr, s);
    for (int i = 15; i >= 0; i--) begin
      bit_slot(wd[i], wr, s);
      rd[i] = s;
    end
    bit_slot(1'b1, 1'b0, s);
  endtask : frame
endmodule : pbc_mac_model

// [testbench/tb_phy_basic_control_register.sv]
// testbench of the phy basic control register
`include "pbc_defines.svh"
module tb_phy_basic_control_register import pbc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_n = 1'b0, mdc, m_val, m_en, dev_out, dev_oe_n;
  logic cfg_ov = 1'b0, cfg_val = 1'b0, link_pd = 1'b0;
  logic an_spd = 1'b1, an_fd = 1'b0;
  logic [15:0] rd;
  wire mdio_w;
  pbc_mode_type mode;
  int num_errors = 0, num_checks = 0, restarts = 0, rst_cycles = 0;

  always #25 mclk = ~mclk;
  // pull-up holds the line high when nobody drives it
  assign mdio_w = !dev_oe_n ? dev_out : m_en ? m_val : 1'b1;
  always @(posedge mclk) begin
    if (mode.an_restart === 1'b1) restarts <= restarts + 1;
    if (mode.soft_reset === 1'b1) rst_cycles <= rst_cycles + 1;
  end

  pbc_ctrl_reg pbc_ctrl_reg_inst (.mclk_i(mclk), .rst_n_i(rst_n),
    .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(dev_out), .mdio_oe_n_o(dev_oe_n),
    .cfg_loop_override_i(cfg_ov), .cfg_loop_value_i(cfg_val),
    .link_power_down_i(link_pd), .an_speed_100_i(an_spd),
    .an_full_duplex_i(an_fd), .mode_o(mode));
  pbc_mac_model pbc_mac_model_inst (.clk_i(mclk), .mdio_i(mdio_w),
    .mdc_o(mdc), .mdio_o(m_val), .mdio_en_o(m_en));

  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk
  task automatic wr(input logic [15:0] d);
    pbc_mac_model_inst.frame(`PBC_OP_WRITE, `PBC_PHY_ADDR, `PBC_REG_CTRL,
      d, rd);
    repeat (4) @(posedge mclk);
  endtask : wr
  task automatic rd_chk(input string what, input logic [15:0] exp);
    pbc_mac_model_inst.frame(`PBC_OP_READ, `PBC_PHY_ADDR, `PBC_REG_CTRL,
      16'h0000, rd);
    chk(what, exp, rd);
  endtask : rd_chk
  // wait out the input synchronisers before looking
  task automatic mode_chk(input string what, input logic [7:0] exp);
    repeat (6) @(posedge mclk);
    chk(what, {8'h00, exp}, {8'h00, mode});
  endtask : mode_chk

  task automatic t_defaults;
    rd_chk("reset value", 16'h3180);
    mode_chk("reset mode", 8'h50);
  endtask : t_defaults
  task automatic t_manual;
    wr(16'h0100);
    rd_chk("manual full", 16'h0100);
    mode_chk("10 full", 8'h20);
    wr(16'h2000);
    rd_chk("manual 100", 16'h2000);
    mode_chk("100 half", 8'h40);
  endtask : t_manual
  task automatic t_autoneg;
    wr(16'h1000);
    rd_chk("duplex under an", 16'h1100);
    mode_chk("an result", 8'h50);
    an_spd <= 1'b0;
    an_fd <= 1'b1;
    mode_chk("an follows link", 8'h30);
    an_spd <= 1'b1;
    an_fd <= 1'b0;
  endtask : t_autoneg
  task automatic t_loopback;
    wr(16'h4000);
    repeat (12) @(posedge mclk);
    rd_chk("loop bit", 16'h4000);
    mode_chk("loop forces full", 8'hA0);
    cfg_ov <= 1'b1;
    mode_chk("config off wins", 8'h00);
    wr(16'h0000);
    cfg_val <= 1'b1;
    mode_chk("config on wins", 8'hA0);
    cfg_ov <= 1'b0;
    cfg_val <= 1'b0;
    mode_chk("no loop", 8'h00);
  endtask : t_loopback
  task automatic t_power;
    wr(16'h0C00);
    rd_chk("bit 7 cleared", 16'h0C00);
    mode_chk("low power isolate", 8'h06);
    wr(16'h0000);
    link_pd <= 1'b1;
    mode_chk("link power down", 8'h04);
    link_pd <= 1'b0;
    mode_chk("power up", 8'h00);
  endtask : t_power
  task automatic t_restart;
    int n;
    n = restarts;
    wr(16'h1200);
    chk("restart pulse", 16'(n + 1), 16'(restarts));
    rd_chk("restart cleared", 16'h1100);
    wr(16'h1000);
    chk("zero no restart", 16'(n + 1), 16'(restarts));
  endtask : t_restart
  task automatic t_soft_reset;
    int n;
    wr(16'h0C80);
    n = rst_cycles;
    wr(16'h8000);
    repeat (30) @(posedge mclk);
    chk("reset long", 16'h0001,
      16'(rst_cycles - n >= `PBC_SWRST_CYC));
    rd_chk("defaults back", 16'h3180);
    mode_chk("defaults mode", 8'h50);
  endtask : t_soft_reset
  task automatic t_bad_addr;
    pbc_mac_model_inst.frame(`PBC_OP_WRITE, 5'h02, `PBC_REG_CTRL,
      16'h0000, rd);
    pbc_mac_model_inst.frame(`PBC_OP_WRITE, `PBC_PHY_ADDR, 5'h01,
      16'h0000, rd);
    pbc_mac_model_inst.frame(`PBC_OP_READ, 5'h02, `PBC_REG_CTRL,
      16'h0000, rd);
    chk("other phy silent", 16'hFFFF, rd);
    rd_chk("not written", 16'h3180);
  endtask : t_bad_addr

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_defaults();
    t_manual();
    t_autoneg();
    t_loopback();
    t_power();
    t_restart();
    t_soft_reset();
    t_bad_addr();
    end_sim();
  end
  // about 23 frames of 650 cycles are expected
  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    end_sim();
  end
endmodule : tb_phy_basic_control_register
